/* File: rtl/nbc_defs.svh */
`ifndef NBC_DEFS_SVH
`define NBC_DEFS_SVH
// What this block does
// R01: Device latches bus on input strobe rise.
// R02: Device floats data pins when deselected.
// R03: Command latch high marks command cycle.
// R04: Address latch high marks address cycle.
// R05: Chip select low during every bus operation.
// R06: Input strobe alone times device latching.
// R07: Device drives word while output strobe low.
// R08: Output strobe fall advances column by one.
// R09: Write protect low blocks program and erase.
// R10: Ready/busy open-drain output shows device state.
// R11: Byte mode: five cycles, column A0-A11.
// R12: Word mode: five cycles, column A0-A10.
// R13: Unused address bits are driven low.
// R14: Decode base command opcode set.
// R15: Decode two-plane, random and cache opcodes.
// R16: Copy-back error status only after copy-back.
// R17: One latch high, strobe high, protect high.
// R18: Data out with latches low, strobe toggling.
// R19: Upper data byte only in word mode.
// R20: Command opcodes always on low byte.
// R21: While busy only status and reset.
// R22: Program confirm needs preceding data load; checked only after NBC_C_PROG, so a bare confirm after reset is taken.
// R23: Ready/busy low throughout internal operation.

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define NBC_CLK_MHZ 10
`define NBC_CYC(ns) (((ns) * `NBC_CLK_MHZ + 999) / 1000)
`define NBC_T_WP_NS 25
`define NBC_T_WH_NS 15
`define NBC_T_REA_NS 30
`define NBC_T_WB_NS 100
`define NBC_SYNC_STAGES 2
`define NBC_WP_CYC `NBC_CYC(`NBC_T_WP_NS)
`define NBC_WH_CYC `NBC_CYC(`NBC_T_WH_NS)
`define NBC_WB_CYC `NBC_CYC(`NBC_T_WB_NS)
`define NBC_RD_CYC (`NBC_CYC(`NBC_T_REA_NS) + `NBC_SYNC_STAGES)

// ----------------------------------------------------------------
// Address layout and opcodes
// ----------------------------------------------------------------
`define NBC_ADDR_CYCLES 5
`define NBC_COL_W8 12
`define NBC_COL_W16 11
`define NBC_C_READ 8'h00
`define NBC_C_READ_GO 8'h30
`define NBC_C_CB_READ 8'h35
`define NBC_C_ID 8'h90
`define NBC_C_RESET 8'hff
`define NBC_C_PROG 8'h80
`define NBC_C_PROG_GO 8'h10
`define NBC_C_CB_PROG 8'h85
`define NBC_C_PLANE 8'h11
`define NBC_C_PLANE2 8'h81
`define NBC_C_ERASE 8'h60
`define NBC_C_ERASE_GO 8'hd0
`define NBC_C_STATUS 8'h70
`define NBC_C_RND_OUT 8'h05
`define NBC_C_RND_OUT_GO 8'he0
`define NBC_C_CACHE 8'h31
`define NBC_C_CACHE_END 8'h3f
`define NBC_C_CB_STATUS 8'h7b
`endif

/* File: rtl/nbc_pkg.sv */
package nbc_pkg;
  typedef enum logic [2:0] {
    NBC_OP_CMD = 3'h0,
    NBC_OP_ADDR = 3'h1,
    NBC_OP_WRITE = 3'h2,
    NBC_OP_READ = 3'h3,
    NBC_OP_WAIT = 3'h4
  } nbc_op_t;

  typedef struct packed {
    nbc_op_t op;
    logic [15:0] data;
    logic [28:0] addr;
  } nbc_req_t;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic output_strobe_n;
    logic wp_n;
    logic [15:0] dq_o;
    logic [15:0] dq_oe;
  } nbc_pins_t;

  typedef enum logic [2:0] {
    NBC_IDLE = 3'b000,
    NBC_SETUP = 3'b001,
    NBC_WR_LO = 3'b011,
    NBC_WR_HI = 3'b010,
    NBC_RD_LO = 3'b110,
    NBC_RD_HI = 3'b111,
    NBC_WB_DLY = 3'b101,
    NBC_WAIT_RB = 3'b100
  } nbc_state_t;
endpackage

/* File: rtl/nbc_word_buf.sv */
`timescale 1ns/1ps
module nbc_word_buf #(
  parameter int W = 16,
  parameter int D = 2
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0] mem_q [D];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;

  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  wire [PW-1:0] wr_nx = (wr_q == PW'(D - 1)) ? '0 : wr_q + 1'b1;
  wire [PW-1:0] rd_nx = (rd_q == PW'(D - 1)) ? '0 : rd_q + 1'b1;

  assign in_ready_o = (cnt_q != (PW + 1)'(D));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_nx;
      if (pop) rd_q <= rd_nx;
      cnt_q <= cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end

  // The array holds no control state, so it needs no reset.
  always_ff @(posedge mclk_i) begin
    if (push) mem_q[wr_q] <= in_data_i;
  end
endmodule

/* File: rtl/nbc_host.sv */
`timescale 1ns/1ps
`include "nbc_defs.svh"
module nbc_host (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic bus_wide_i,
  input wire logic wp_lock_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire nbc_pkg::nbc_req_t req_i,
  output logic done_o,
  output logic err_o,
  output logic dev_ready_o,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [15:0] rd_data_o,
  output nbc_pkg::nbc_pins_t pins_o,
  input wire logic [15:0] dq_i,
  input wire logic rb_i
);
  import nbc_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [15:0] dq_s1_q, dq_s2_q;
  logic rb_s1_q, rb_s2_q;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
      rb_s1_q <= 1'b0;
      rb_s2_q <= 1'b0;
    end else begin
      dq_s1_q <= dq_i;
      dq_s2_q <= dq_s1_q;
      rb_s1_q <= rb_i;
      rb_s2_q <= rb_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  nbc_state_t st_q, st_d;
  nbc_op_t op_q, op_d;
  logic [3:0] tmr_q, tmr_d;
  logic [2:0] acnt_q, acnt_d;
  logic [28:0] addr_q, addr_d;
  logic wide_q, wide_d;
  logic ce_n_q, ce_n_d, cle_q, cle_d, ale_q, ale_d;
  logic we_n_q, we_n_d, ostb_n_q, ostb_n_d, oe_q, oe_d;
  logic [15:0] dq_q, dq_d;
  logic done_q, done_d, err_q, err_d;
  logic push_q, push_d;
  logic [15:0] pdata_q;
  logic wp_n_q;
  logic armed_q, loaded_q, cb_q;
  logic buf_in_ready;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire [7:0] cmd = req_i.data[7:0];
  wire busy = !rb_s2_q; // R10 R23
  wire cmd_known = cmd inside {`NBC_C_READ, `NBC_C_READ_GO, // R14 R15
    `NBC_C_CB_READ, `NBC_C_ID, `NBC_C_RESET, `NBC_C_PROG,
    `NBC_C_PROG_GO, `NBC_C_CB_PROG, `NBC_C_PLANE, `NBC_C_PLANE2,
    `NBC_C_ERASE, `NBC_C_ERASE_GO, `NBC_C_STATUS, `NBC_C_RND_OUT,
    `NBC_C_RND_OUT_GO, `NBC_C_CACHE, `NBC_C_CACHE_END,
    `NBC_C_CB_STATUS};
  wire cmd_modify = cmd inside {`NBC_C_PROG, `NBC_C_PROG_GO,
    `NBC_C_CB_PROG, `NBC_C_PLANE, `NBC_C_PLANE2, `NBC_C_ERASE,
    `NBC_C_ERASE_GO};
  wire cmd_busy_ok = (cmd == `NBC_C_STATUS) || (cmd == `NBC_C_RESET);
  wire is_cmd = (req_i.op == NBC_OP_CMD);
  wire refuse = is_cmd && (!cmd_known
    || (busy && !cmd_busy_ok) // R21
    || (wp_lock_i && cmd_modify) // R09 R17
    || (cmd == `NBC_C_CB_STATUS && !cb_q) // R16
    || (cmd == `NBC_C_PROG_GO && armed_q && !loaded_q)); // R22
  wire rd_stall = (req_i.op == NBC_OP_READ) && !buf_in_ready;
  wire take = req_valid_i && req_ready_o;
  wire cmd_ok = take && is_cmd && !refuse;
  wire wr_ok = take && (req_i.op == NBC_OP_WRITE);

  assign req_ready_o = (st_q == NBC_IDLE) && !rd_stall;

  // Unused positions of every address cycle come out as zero.
  function automatic logic [7:0] addr_byte(input logic [28:0] a,
                                           input logic w,
                                           input logic [2:0] i);
    logic [11:0] col;
    logic [16:0] row;
    col = w ? {1'b0, a[`NBC_COL_W16-1:0]} : a[`NBC_COL_W8-1:0]; // R11 R12
    row = w ? a[`NBC_COL_W16+16:`NBC_COL_W16] // R12
            : a[`NBC_COL_W8+16:`NBC_COL_W8]; // R11
    unique case (i)
      3'h0: addr_byte = col[7:0];
      3'h1: addr_byte = {4'h0, col[11:8]}; // R13
      3'h2: addr_byte = row[7:0];
      3'h3: addr_byte = row[15:8];
      default: addr_byte = {7'h00, row[16]}; // R13
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    tmr_d = (tmr_q != '0) ? tmr_q - 4'h1 : tmr_q;
    acnt_d = acnt_q;
    addr_d = addr_q;
    wide_d = wide_q;
    ce_n_d = ce_n_q;
    cle_d = cle_q;
    ale_d = ale_q;
    we_n_d = we_n_q;
    ostb_n_d = ostb_n_q;
    oe_d = oe_q;
    dq_d = dq_q;
    done_d = 1'b0;
    err_d = 1'b0;
    push_d = 1'b0;
    unique case (st_q)
      NBC_IDLE: begin
        if (take && refuse) begin
          err_d = 1'b1;
        end else if (take) begin
          op_d = req_i.op;
          addr_d = req_i.addr;
          wide_d = bus_wide_i;
          acnt_d = '0;
          tmr_d = 4'(`NBC_WH_CYC - 1);
          unique case (req_i.op)
            NBC_OP_READ: begin
              ce_n_d = 1'b0; // R05 R18
              ostb_n_d = 1'b0;
              tmr_d = 4'(`NBC_RD_CYC - 1);
              st_d = NBC_RD_LO;
            end
            NBC_OP_WAIT: begin
              tmr_d = 4'(`NBC_WB_CYC - 1);
              st_d = NBC_WB_DLY;
            end
            default: begin
              ce_n_d = 1'b0; // R05
              cle_d = is_cmd; // R03 R17
              ale_d = (req_i.op == NBC_OP_ADDR); // R04 R17
              oe_d = 1'b1;
              if (is_cmd) begin
                dq_d = {8'h00, cmd}; // R20
              end else if (req_i.op == NBC_OP_ADDR) begin
                dq_d = {8'h00, addr_byte(req_i.addr, bus_wide_i, 3'h0)};
              end else begin
                dq_d = bus_wide_i ? req_i.data : {8'h00, cmd}; // R19
              end
              st_d = NBC_SETUP;
            end
          endcase
        end
      end
      NBC_SETUP: begin
        if (tmr_q == '0) begin
          we_n_d = 1'b0;
          tmr_d = 4'(`NBC_WP_CYC - 1);
          st_d = NBC_WR_LO;
        end
      end
      NBC_WR_LO: begin
        if (tmr_q == '0) begin
          we_n_d = 1'b1; // R01 R06
          tmr_d = 4'(`NBC_WH_CYC - 1);
          st_d = NBC_WR_HI;
        end
      end
      NBC_WR_HI: begin
        if (tmr_q == '0) begin
          if (op_q == NBC_OP_ADDR
              && acnt_q != 3'(`NBC_ADDR_CYCLES - 1)) begin
            acnt_d = acnt_q + 3'h1; // R11 R12
            dq_d = {8'h00, addr_byte(addr_q, wide_q, acnt_q + 3'h1)};
            tmr_d = 4'(`NBC_WH_CYC - 1);
            st_d = NBC_SETUP;
          end else begin
            ce_n_d = 1'b1;
            cle_d = 1'b0;
            ale_d = 1'b0;
            oe_d = 1'b0;
            done_d = 1'b1;
            st_d = NBC_IDLE;
          end
        end
      end
      NBC_RD_LO: begin
        if (tmr_q == '0) begin
          push_d = 1'b1; // R07 R08
          ostb_n_d = 1'b1;
          tmr_d = 4'(`NBC_WH_CYC - 1);
          st_d = NBC_RD_HI;
        end
      end
      NBC_RD_HI: begin
        if (tmr_q == '0) begin
          ce_n_d = 1'b1;
          done_d = 1'b1;
          st_d = NBC_IDLE;
        end
      end
      NBC_WB_DLY: begin
        if (tmr_q == '0) st_d = NBC_WAIT_RB;
      end
      NBC_WAIT_RB: begin
        if (!busy) begin // R23
          done_d = 1'b1;
          st_d = NBC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= NBC_IDLE;
      op_q <= NBC_OP_CMD;
      tmr_q <= '0;
      acnt_q <= '0;
      addr_q <= '0;
      wide_q <= 1'b0;
      {ce_n_q, we_n_q, ostb_n_q} <= 3'h7;
      {cle_q, ale_q, oe_q} <= 3'h0;
      dq_q <= '0;
      {done_q, err_q, push_q} <= 3'h0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      tmr_q <= tmr_d;
      acnt_q <= acnt_d;
      addr_q <= addr_d;
      wide_q <= wide_d;
      {ce_n_q, we_n_q, ostb_n_q} <= {ce_n_d, we_n_d, ostb_n_d};
      {cle_q, ale_q, oe_q} <= {cle_d, ale_d, oe_d};
      dq_q <= dq_d;
      {done_q, err_q, push_q} <= {done_d, err_d, push_d};
    end
  end

  // ----------------------------------------------------------------
  // Command history and protection
  // ----------------------------------------------------------------
  // Protect starts asserted so nothing can be modified during reset.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_n_q <= 1'b0;
      armed_q <= 1'b0;
      loaded_q <= 1'b0;
      cb_q <= 1'b0;
      pdata_q <= '0;
    end else begin
      wp_n_q <= !wp_lock_i; // R09
      if (push_d) pdata_q <= wide_q ? dq_s2_q : {8'h00, dq_s2_q[7:0]};
      if (cmd_ok && cmd == `NBC_C_PROG) begin
        armed_q <= 1'b1; // R22
        loaded_q <= 1'b0;
      end else if (cmd_ok && cmd == `NBC_C_CB_PROG) begin
        loaded_q <= 1'b1;
      end else if (cmd_ok && cmd == `NBC_C_PROG_GO) begin
        armed_q <= 1'b0;
      end else if (wr_ok) begin
        loaded_q <= 1'b1;
      end
      if (cmd_ok && (cmd == `NBC_C_CB_READ || cmd == `NBC_C_CB_PROG)) begin
        cb_q <= 1'b1; // R16
      end else if (cmd_ok && (cmd == `NBC_C_PROG || cmd == `NBC_C_ERASE
                   || cmd == `NBC_C_READ_GO || cmd == `NBC_C_ID
                   || cmd == `NBC_C_RESET)) begin
        cb_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data path
  // ----------------------------------------------------------------
  // A read starts only with a free slot, so no captured word is lost.
  nbc_word_buf #(.W(16), .D(2)) u_buf (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(push_q),
    .in_ready_o(buf_in_ready),
    .in_data_i(pdata_q),
    .out_valid_o(rd_valid_o),
    .out_ready_i(rd_ready_i),
    .out_data_o(rd_data_o)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pins_o.ce_n = ce_n_q;
  assign pins_o.cle = cle_q;
  assign pins_o.ale = ale_q;
  assign pins_o.we_n = we_n_q;
  assign pins_o.output_strobe_n = ostb_n_q; // R18
  assign pins_o.wp_n = wp_n_q;
  assign pins_o.dq_o = dq_q;
  assign pins_o.dq_oe = {{8{oe_q && wide_q}}, {8{oe_q}}}; // R02 R19
  assign done_o = done_q;
  assign err_o = err_q;
  assign dev_ready_o = rb_s2_q;
endmodule

/* File: tb/nbc_flash_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Behavioural flash device on the far side of the host pins.
// ----------------------------------------------------------------
module nbc_flash_model (
  input wire nbc_pkg::nbc_pins_t pins_i,
  input wire logic [15:0] bus_i,
  input wire logic wide_i,
  output logic [15:0] dq_o,
  output logic busy_o
);
  import nbc_pkg::*;
  logic [15:0] abyte [5];
  logic [15:0] col_q = '0;
  logic [15:0] word_q = '0;
  logic drive;
  int acnt = 0;
  int wcnt = 0;
  int prog_cnt = 0;
  realtime busy_end = 0;
  initial busy_o = 1'b0;
  task automatic go_busy(input int ns);
    busy_o = 1'b1;
    busy_end = $realtime + ns;
  endtask
  always #10 if (busy_o && $realtime >= busy_end) busy_o = 1'b0;
  always @(posedge pins_i.we_n) begin
    if (!pins_i.ce_n && pins_i.output_strobe_n) begin
      if (pins_i.cle) begin
        if (!busy_o || bus_i[7:0] inside {8'h70, 8'hff}) begin
          acnt = 0;
          case (bus_i[7:0])
            8'h80: wcnt = 0;
            8'h30, 8'h35, 8'h31: begin
              col_q = {abyte[1][7:0], abyte[0][7:0]};
              go_busy(2000);
            end
            8'h10: if (pins_i.wp_n && wcnt > 0) begin
              prog_cnt++;
              go_busy(3000);
            end
            8'hd0: if (pins_i.wp_n) go_busy(3000);
            8'hff: go_busy(500);
            default: ;
          endcase
        end
      end else if (pins_i.ale && acnt < 5) begin
        abyte[acnt] = wide_i ? bus_i : {8'h00, bus_i[7:0]};
        acnt++;
      end else if (!pins_i.ale && pins_i.wp_n) begin
        wcnt++;
      end
    end
  end
  always @(negedge pins_i.output_strobe_n) begin
    if (!pins_i.ce_n) begin
      word_q = {col_q[7:0] ^ 8'h3c, ~col_q[7:0]};
      col_q = col_q + 16'h1;
    end
  end
  // A released bus shows the inverse of its last word, so a host that
  // samples a floating bus cannot pass by luck.
  assign drive = !pins_i.ce_n && !pins_i.output_strobe_n;
  assign dq_o = drive ? word_q : ~word_q;
endmodule

/* File: tb/nbc_host_asserts.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Pin and handshake checks.
// ----------------------------------------------------------------
module nbc_host_asserts (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic bus_wide_i,
  input wire logic wp_lock_i,
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire nbc_pkg::nbc_req_t req_i,
  input wire logic done_o,
  input wire logic err_o,
  input wire logic rd_valid_o,
  input wire nbc_pkg::nbc_pins_t pins_o
);
  import nbc_pkg::*;
  logic take;
  logic we_q;
  logic [2:0] acnt_q;
  logic [7:0] op_q;
  assign take = req_valid_i && req_ready_o;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      we_q <= 1'b1;
      acnt_q <= 3'h0;
      op_q <= 8'h00;
    end else begin
      we_q <= pins_o.we_n;
      acnt_q <= !pins_o.ale ? 3'h0 : acnt_q + {2'h0, we_q && !pins_o.we_n};
      op_q <= take ? req_i.data[7:0] : op_q;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  AST_ONE_LATCH: assert property (!(pins_o.cle && pins_o.ale))
    else $error("both latch lines high");
  AST_WE_SEL: assert property (!pins_o.we_n |-> !pins_o.ce_n &&
    pins_o.output_strobe_n) else $error("input strobe outside select");
  AST_RD_PHASE: assert property (!pins_o.output_strobe_n |->
    !pins_o.ce_n && pins_o.we_n && !pins_o.cle && !pins_o.ale &&
    pins_o.dq_oe == 16'h0000) else $error("bad data out phase");
  AST_WE_DATA: assert property ($rose(pins_o.we_n) |->
    $stable(pins_o.dq_o) && pins_o.dq_oe[7:0] == 8'hff)
    else $error("bus not held at strobe rise");
  AST_WP_PIN: assert property (1'b1 |=> pins_o.wp_n == !$past(wp_lock_i))
    else $error("protect pin wrong");
  AST_UPPER: assert property (!bus_wide_i |->
    pins_o.dq_oe[15:8] == 8'h00) else $error("upper byte driven");
  AST_CMD_LOW: assert property (take && req_i.op == NBC_OP_CMD |->
    ##[1:2] (err_o || (pins_o.cle && !pins_o.ce_n &&
    pins_o.dq_o[7:0] == op_q))) else $error("command cycle wrong");
  AST_CMD_TIME: assert property (take && req_i.op == NBC_OP_CMD |->
    (##1 err_o) or (##4 done_o)) else $error("command answer late");
  AST_ERR_QUIET: assert property (err_o |-> pins_o.ce_n &&
    $past(pins_o.ce_n)) else $error("refused request touched pins");
  AST_ADDR_FIVE: assert property ($fell(pins_o.ale) |->
    acnt_q == 3'h5) else $error("address cycle count wrong");
  AST_ADDR_TIME: assert property (take && req_i.op == NBC_OP_ADDR |->
    ##16 done_o) else $error("address phase length wrong");
  AST_READ_TIME: assert property (take && req_i.op == NBC_OP_READ |->
    ##5 done_o ##1 rd_valid_o) else $error("read word late");
endmodule
bind nbc_host nbc_host_asserts nbc_host_asserts_inst (.mclk_i, .rst_n_i,
  .bus_wide_i, .wp_lock_i, .req_valid_i, .req_ready_o, .req_i, .done_o,
  .err_o, .rd_valid_o, .pins_o);

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Directed bench for the flash host.
// ----------------------------------------------------------------
module tb_top;
  import nbc_pkg::*;
  logic mclk_i, rst_n_i, bus_wide_i, wp_lock_i, req_valid_i, rd_ready_i;
  logic req_ready_o, done_o, err_o, dev_ready_o, rd_valid_o, dev_busy;
  logic [15:0] rd_data_o, dq_i, dev_dq;
  nbc_req_t req_i;
  nbc_pins_t pins_o;
  int n_fail = 0;
  int n_checks = 0;
  assign dq_i = (pins_o.dq_oe & pins_o.dq_o) | (~pins_o.dq_oe & dev_dq);
  nbc_host nbc_host_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .bus_wide_i(bus_wide_i), .wp_lock_i(wp_lock_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_i(req_i),
    .done_o(done_o), .err_o(err_o), .dev_ready_o(dev_ready_o),
    .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i),
    .rd_data_o(rd_data_o), .pins_o(pins_o), .dq_i(dq_i), .rb_i(!dev_busy));
  nbc_flash_model nbc_flash_model_inst (.pins_i(pins_o), .bus_i(dq_i),
    .wide_i(bus_wide_i), .dq_o(dev_dq), .busy_o(dev_busy));
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic req(input nbc_op_t op, input logic [15:0] d,
      input logic [28:0] a, output logic e);
    int k;
    req_i = '{op: op, data: d, addr: a};
    req_valid_i = 1'b1;
    for (k = 0; req_ready_o !== 1'b1 && k < 300; k++) tick(1);
    tick(1);
    req_valid_i = 1'b0;
    for (k = 0; done_o !== 1'b1 && err_o !== 1'b1 && k < 300; k++) tick(1);
    e = err_o;
    if (k >= 300) n_fail++;
    // A refused request answers at once, so let an edge pass before
    // the next request raises valid again.
    tick(1);
  endtask
  task automatic cmd(input logic [7:0] c, output logic e);
    req(NBC_OP_CMD, {8'h00, c}, 29'h0, e);
  endtask
  task automatic pop(input logic [15:0] x);
    int k;
    rd_ready_i = 1'b1;
    for (k = 0; rd_valid_o !== 1'b1 && k < 50; k++) tick(1);
    chk(rd_data_o, x);
    tick(1);
    rd_ready_i = 1'b0;
    tick(1);
  endtask
  function automatic logic [15:0] abyte_exp(input logic [28:0] a,
      input logic w, input int i);
    logic [11:0] c;
    logic [16:0] r;
    c = w ? {1'b0, a[10:0]} : a[11:0];
    r = w ? a[27:11] : a[28:12];
    case (i)
      0: return {8'h00, c[7:0]};
      1: return {12'h000, c[11:8]};
      2: return {8'h00, r[7:0]};
      3: return {8'h00, r[15:8]};
      default: return {15'h0000, r[16]};
    endcase
  endfunction
  task automatic t_addr();
    logic e;
    logic [28:0] a;
    for (int w = 0; w < 2; w++) begin
      bus_wide_i = w[0];
      a = w[0] ? 29'h0a5c3e17 : 29'h1b6d2f49;
      cmd(8'h00, e);
      req(NBC_OP_ADDR, 16'h0000, a, e);
      for (int i = 0; i < 5; i++) begin
        chk(nbc_flash_model_inst.abyte[i], abyte_exp(a, w[0], i));
      end
    end
    $display("address test done");
  endtask
  task automatic t_read();
    logic e;
    bus_wide_i = 1'b1;
    cmd(8'h00, e);
    req(NBC_OP_ADDR, 16'h0000, 29'h00003805, e);
    cmd(8'h30, e);
    chk(dev_busy, 1'b1);
    req(NBC_OP_WAIT, 16'h0000, 29'h0, e);
    chk(dev_ready_o, 1'b1);
    req(NBC_OP_READ, 16'h0000, 29'h0, e);
    req(NBC_OP_READ, 16'h0000, 29'h0, e);
    tick(2);
    chk(req_ready_o, 1'b0);
    pop({8'h05 ^ 8'h3c, ~8'h05});
    pop({8'h06 ^ 8'h3c, ~8'h06});
    req(NBC_OP_READ, 16'h0000, 29'h0, e);
    pop({8'h07 ^ 8'h3c, ~8'h07});
    $display("read test done");
  endtask
  task automatic t_prog();
    logic e;
    bus_wide_i = 1'b0;
    cmd(8'h80, e);
    req(NBC_OP_ADDR, 16'h0000, 29'h00012345, e);
    cmd(8'h10, e);
    chk(e, 1'b1);
    req(NBC_OP_WRITE, 16'h00a5, 29'h0, e);
    req(NBC_OP_WRITE, 16'h005a, 29'h0, e);
    cmd(8'h10, e);
    chk(nbc_flash_model_inst.wcnt, 2);
    cmd(8'h90, e);
    chk(e, 1'b1);
    cmd(8'h70, e);
    chk(e, 1'b0);
    req(NBC_OP_WAIT, 16'h0000, 29'h0, e);
    chk(nbc_flash_model_inst.prog_cnt, 1);
    $display("program test done");
  endtask
  task automatic t_wp();
    logic e;
    wp_lock_i = 1'b1;
    tick(2);
    chk(pins_o.wp_n, 1'b0);
    cmd(8'h60, e);
    chk(e, 1'b1);
    wp_lock_i = 1'b0;
    tick(2);
    $display("protect test done");
  endtask
  task automatic t_cmds();
    logic e;
    logic [7:0] ops [18] = '{8'h00, 8'h35, 8'h7b, 8'h90, 8'h05, 8'he0,
      8'h31, 8'h3f, 8'h60, 8'h60, 8'hd0, 8'h70, 8'h85, 8'h11, 8'h81,
      8'hff, 8'h7b, 8'h42};
    logic [17:0] bad = 18'h30000;
    for (int i = 0; i < 18; i++) begin
      cmd(ops[i], e);
      chk(e, bad[i]);
      req(NBC_OP_WAIT, 16'h0000, 29'h0, e);
    end
    $display("command set test done");
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  initial begin
    rst_n_i = 1'b0;
    bus_wide_i = 1'b0;
    wp_lock_i = 1'b0;
    req_valid_i = 1'b0;
    rd_ready_i = 1'b0;
    req_i = '0;
    repeat (20) @(posedge mclk_i);
    #1;
    rst_n_i = 1'b1;
    tick(5);
    t_addr();
    t_read();
    t_prog();
    t_wp();
    t_cmds();
    results();
  end
  // The whole run needs well under a tenth of this span.
  initial begin
    #1000000;
    n_fail++;
    results();
  end
endmodule
